// file: hw/lcdd_params.svh
// constants for the serial display command decoder
// assumes a 10 MHz pclk and a 32.768 kHz crystal rate derived from it
`ifndef LCDD_PARAMS_SVH
`define LCDD_PARAMS_SVH
`define LCDD_PCLK_HZ     24'h989680
`define LCDD_XTAL_HZ     24'h008000
`define LCDD_ADDR_STATUS 8'h00
`define LCDD_ADDR_CTRL   8'h04
`define LCDD_CTRL_LINK   0
`define LCDD_MODE_READ   3'h6
`define LCDD_MODE_WRITE  3'h5
`define LCDD_MODE_CMD    3'h4
`define LCDD_MODE_LAST   4'h2
`define LCDD_ADDR_LAST   4'h5
`define LCDD_CMD_LAST    4'h8
`define LCDD_NIB_LAST    3'h3
`define LCDD_RATE_RST    3'h7
`define LCDD_WDT_TIMEOUT_S 4
`define LCDD_WDT_LAST    3'(`LCDD_WDT_TIMEOUT_S - 1)
`define LCDD_DIV_ALL     15'h7fff
`define LCDD_DIV_TOP     15'h4000
`define LCDD_TONE_HI_BIT 2
`define LCDD_TONE_LO_BIT 3
`define LCDD_SYNC_RST    4'h7
`define LCDD_ST_OSC      0
`define LCDD_ST_BIAS     1
`define LCDD_ST_TICK     2
`define LCDD_ST_WDT      3
`define LCDD_ST_TONE     4
`define LCDD_ST_TLOW     5
`define LCDD_ST_IRQEN    6
`define LCDD_ST_THIRD    7
`define LCDD_ST_COM      8
`define LCDD_ST_RATE     10
`define LCDD_ST_TEST     13
`define LCDD_ST_WFLAG    14
`define LCDD_ST_IRQ      15
`endif

// file: hw/lcdd_pkg.sv
// types shared by the decoder and its display memory
// assumes lcdd_params.svh for all numeric constants
package lcdd_pkg;
    typedef enum logic [2:0] {FR_MODE, FR_ADDR, FR_DATA, FR_CMD, FR_IDLE} lcdd_frame_t;
    typedef enum logic [4:0] {
        C_NONE, C_OSC_BIAS_OFF, C_OSC_ON, C_BIAS_ON, C_TICK_OFF, C_TICK_ON,
        C_WDT_OFF, C_WDT_ON, C_TONE_OFF, C_TICK_CLR, C_WDT_CLR, C_PANEL,
        C_TONE_HI, C_TONE_LO, C_ALARM_OFF, C_ALARM_ON, C_RATE, C_TEST, C_NORMAL
    } lcdd_cmd_t;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } lcdd_apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } lcdd_apb_rsp_t;
    typedef struct packed {
        logic data;
        logic rd_n;
        logic wr_n;
        logic cs_n;
    } lcdd_link_in_t;
    typedef struct packed {
        logic       data;
        logic       data_oe;
        logic       irq_n;
        logic [1:0] beeper_pair;
    } lcdd_link_out_t;
    typedef struct packed {
        logic       osc_on;
        logic       bias_on;
        logic       tick_en;
        logic       watchdog_flag_on;
        logic       tone_on;
        logic       tone_low;
        logic       irq_en;
        logic       bias_third;
        logic [1:0] commons;
        logic [2:0] rate;
        logic       test_mode;
    } lcdd_cfg_t;
    typedef struct packed {
        logic [3:0]  s1;
        logic [3:0]  s2;
        logic [3:0]  s3;
        lcdd_frame_t fr;
        logic [2:0]  mode;
        logic [3:0]  bitcnt;
        logic [8:0]  shreg;
        logic [5:0]  addr;
        logic [3:0]  wnib;
        logic [2:0]  rcnt;
        logic [2:0]  wcnt;
        logic        dout;
        logic        doe;
        logic        ram_we;
        logic [5:0]  ram_waddr;
        logic [3:0]  ram_wdata;
        lcdd_cfg_t   cfg;
        logic [23:0] acc;
        logic [14:0] div;
        logic [2:0]  wdt_cnt;
        logic        wdt_flag;
        logic        irq_n;
        logic [1:0]  beep;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        link_en;
    } lcdd_state_t;
    typedef struct packed {
        logic [31:0][3:0] mem;
        logic [3:0]       rdata;
    } lcdd_ram_state_t;
endpackage : lcdd_pkg

// file: hw/lcdd_ram.sv
// 32 x 4 display memory, one write port and one registered read port
// assumes the writer and reader share pclk; address bit 5 aliases
module lcdd_ram (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       we,
    input  wire logic [5:0] waddr,
    input  wire logic [3:0] wdata,
    input  wire logic [5:0] raddr,
    output logic      [3:0] rdata
);
    import lcdd_pkg::*;

    lcdd_ram_state_t st_r;
    lcdd_ram_state_t st_nxt;

    // read first, read data is the old word when addresses meet
    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = st_r.mem[raddr[4:0]];
        if (we) begin
            st_nxt.mem[waddr[4:0]] = wdata;
        end
    end

    // memory clears at reset so reads are never unknown
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rdata;
endmodule : lcdd_ram

// file: hw/lcdd_decoder.sv
// serial command and data decoder for a 32x4 segment display driver
// assumes three serial strobes from a host, asynchronous to pclk, and an apb master
// Behaviour
// - read frame: 110, address msb first, nibble out lsb first
// - write frame: 101, address, nibble lsb first, stored
// - 101 frame may read nibble then rewrite it
// - 100 opens command run; later commands need no code
// - command 0000-0000 stops oscillator and bias
// - command 0000-0001 starts the oscillator
// - command 0000-0011 enables bias generator
// - tick output off 0000-0100, on 0000-0010
// - watchdog flag off 0000-0101, on 0000-0111
// - command 0000-1000 silences the beeper pair
// - command 0000-1101 clears time base count
// - command 0000-111x clears watchdog stage
// - panel command bit c picks half or third bias
// - panel field ab picks two, three, four commons
// - beeper pitch 4khz 010x, 2khz 0110
// - 101x-0nnn sets tick 2^n hz, watchdog 4s/2^n
// - 1110-0011 normal, 1110-0000 test mode
// - reset defaults: all off, 128hz rate, normal
// - don't-care bits never affect decoding
// - all rates derive from 32.768khz crystal tick
// - chip select high aborts frame and mode
// - watchdog timeout holds alarm low until cleared
// - input bits sampled on write strobe rising edge
// - read bits driven at read strobe falling edge
`include "lcdd_params.svh"
module lcdd_decoder (
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire lcdd_pkg::lcdd_apb_req_t  apb_i,
    output lcdd_pkg::lcdd_apb_rsp_t       apb_o,
    input  wire lcdd_pkg::lcdd_link_in_t  link_i,
    output lcdd_pkg::lcdd_link_out_t      link_o
);
    import lcdd_pkg::*;

    // command decode on w[8:1], casez keeps every don't-care position out of the match
    function automatic lcdd_cmd_t cmd_decode(input logic [8:0] w);
        lcdd_cmd_t c;
        c = C_NONE;
        casez (w[8:1])
            8'b0000_0000: c = C_OSC_BIAS_OFF;
            8'b0000_0001: c = C_OSC_ON;
            8'b0000_0011: c = C_BIAS_ON;
            8'b0000_0100: c = C_TICK_OFF;
            8'b0000_0010: c = C_TICK_ON;
            8'b0000_0101: c = C_WDT_OFF;
            8'b0000_0111: c = C_WDT_ON;
            8'b0000_1000: c = C_TONE_OFF;
            8'b0000_1101: c = C_TICK_CLR;
            8'b0000_111?: c = C_WDT_CLR;
            8'b0010_0???: c = C_PANEL;
            8'b0010_10??: c = C_PANEL;
            8'b010?_????: c = C_TONE_HI;
            8'b0110_????: c = C_TONE_LO;
            8'b100?_0???: c = C_ALARM_OFF;
            8'b100?_1???: c = C_ALARM_ON;
            8'b101?_0???: c = C_RATE;
            8'b1110_0000: c = C_TEST;
            8'b1110_0011: c = C_NORMAL;
            default:      c = C_NONE;
        endcase
        return c;
    endfunction : cmd_decode

    // status word seen by software
    function automatic logic [31:0] status_word(input lcdd_state_t s);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[`LCDD_ST_OSC]   = s.cfg.osc_on;
        v[`LCDD_ST_BIAS]  = s.cfg.bias_on;
        v[`LCDD_ST_TICK]  = s.cfg.tick_en;
        v[`LCDD_ST_WDT]   = s.cfg.watchdog_flag_on;
        v[`LCDD_ST_TONE]  = s.cfg.tone_on;
        v[`LCDD_ST_TLOW]  = s.cfg.tone_low;
        v[`LCDD_ST_IRQEN] = s.cfg.irq_en;
        v[`LCDD_ST_THIRD] = s.cfg.bias_third;
        v[`LCDD_ST_COM +: 2]  = s.cfg.commons;
        v[`LCDD_ST_RATE +: 3] = s.cfg.rate;
        v[`LCDD_ST_TEST]  = s.cfg.test_mode;
        v[`LCDD_ST_WFLAG] = s.wdt_flag;
        v[`LCDD_ST_IRQ]   = ~s.irq_n;
        return v;
    endfunction : status_word

    // power-on state
    function automatic lcdd_state_t rst_state();
        lcdd_state_t s;
        s = '0;
        s.s1 = `LCDD_SYNC_RST;
        s.s2 = `LCDD_SYNC_RST;
        s.s3 = `LCDD_SYNC_RST;
        s.fr = FR_MODE;
        s.cfg.rate = `LCDD_RATE_RST;
        s.irq_n = 1'b1;
        s.link_en = 1'b1;
        return s;
    endfunction : rst_state

    localparam lcdd_state_t ST_RST = rst_state();

    lcdd_state_t st_r;
    lcdd_state_t st_nxt;
    logic [3:0]  ram_rdata;
    logic        cs_hi;
    logic        wr_rise;
    logic        rd_fall;
    logic        din;
    logic        live;
    logic        fire;
    logic [8:0]  cmd_word;
    lcdd_cmd_t   cmd;
    logic [24:0] acc_sum;
    logic        osc_tick;
    logic [14:0] tb_mask;
    logic        tb_wrap;
    logic        tb_level;
    logic        rd_bit;
    logic [5:0]  addr_inc;
    logic        apb_setup;
    logic        apb_write;

    lcdd_ram u_ram (
        .pclk    (pclk),
        .presetn (presetn),
        .we      (st_r.ram_we),
        .waddr   (st_r.ram_waddr),
        .wdata   (st_r.ram_wdata),
        .raddr   (st_r.addr),
        .rdata   (ram_rdata)
    );

    // edges come from the second and third sync stages only
    assign cs_hi    = st_r.s2[0];
    assign wr_rise  = st_r.s2[1] & ~st_r.s3[1];
    assign rd_fall  = ~st_r.s2[2] & st_r.s3[2];
    assign din      = st_r.s2[3];
    assign live     = ~cs_hi & st_r.link_en;
    assign cmd_word = {st_r.shreg[7:0], din};
    assign cmd      = cmd_decode(cmd_word);
    assign fire     = live & wr_rise & (st_r.fr == FR_CMD) & (st_r.bitcnt == `LCDD_CMD_LAST);
    assign rd_bit   = ram_rdata[st_r.rcnt[1:0]];
    assign addr_inc = st_r.addr + 6'h01;

    // crystal tick by phase accumulation; 10 MHz is no multiple of it, so ticks jitter one pclk
    assign acc_sum  = {1'b0, st_r.acc} + {1'b0, `LCDD_XTAL_HZ};
    assign osc_tick = st_r.cfg.osc_on & (acc_sum >= {1'b0, `LCDD_PCLK_HZ});
    // time base bit 14-n of the crystal count gives 2^n hz
    assign tb_mask  = `LCDD_DIV_ALL >> st_r.cfg.rate;
    assign tb_wrap  = osc_tick & ((st_r.div & tb_mask) == tb_mask);
    assign tb_level = |(st_r.div & (`LCDD_DIV_TOP >> st_r.cfg.rate));

    assign apb_setup = apb_i.psel & ~apb_i.penable;
    assign apb_write = apb_i.psel & apb_i.penable & st_r.pready & apb_i.pwrite;

    always_comb begin
        logic wdt_set;
        wdt_set = 1'b0;
        st_nxt = st_r;
        st_nxt.ram_we = 1'b0;

        // two-flop synchronisers plus an edge history stage
        st_nxt.s1 = link_i;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;

        // serial frame engine
        if (!live) begin
            st_nxt.fr = FR_MODE;
            st_nxt.bitcnt = 4'h0;
            st_nxt.rcnt = 3'h0;
            st_nxt.wcnt = 3'h0;
            st_nxt.doe = 1'b0;
        end else if (wr_rise) begin
            unique case (st_r.fr)
                FR_MODE: begin
                    st_nxt.mode = {st_r.mode[1:0], din};
                    st_nxt.bitcnt = st_r.bitcnt + 4'h1;
                    if (st_r.bitcnt == `LCDD_MODE_LAST) begin
                        st_nxt.bitcnt = 4'h0;
                        if ({st_r.mode[1:0], din} == `LCDD_MODE_READ ||
                            {st_r.mode[1:0], din} == `LCDD_MODE_WRITE) begin
                            st_nxt.fr = FR_ADDR;
                        end else if ({st_r.mode[1:0], din} == `LCDD_MODE_CMD) begin
                            st_nxt.fr = FR_CMD;
                        end else begin
                            st_nxt.fr = FR_IDLE;
                        end
                    end
                end
                FR_ADDR: begin
                    st_nxt.addr = {st_r.addr[4:0], din}; // msb first
                    st_nxt.bitcnt = st_r.bitcnt + 4'h1;
                    if (st_r.bitcnt == `LCDD_ADDR_LAST) begin
                        st_nxt.bitcnt = 4'h0;
                        st_nxt.rcnt = 3'h0;
                        st_nxt.wcnt = 3'h0;
                        st_nxt.fr = FR_DATA;
                    end
                end
                FR_DATA: begin
                    // write strobes in a read frame are ignored
                    if (st_r.mode == `LCDD_MODE_WRITE) begin
                        st_nxt.doe = 1'b0;
                        st_nxt.wnib[st_r.wcnt[1:0]] = din;
                        st_nxt.wcnt = st_r.wcnt + 3'h1;
                        if (st_r.wcnt == `LCDD_NIB_LAST) begin
                            st_nxt.ram_we = 1'b1;
                            st_nxt.ram_waddr = st_r.addr;
                            st_nxt.ram_wdata = {din, st_r.wnib[2:0]};
                            st_nxt.addr = addr_inc;
                            st_nxt.wcnt = 3'h0;
                            st_nxt.rcnt = 3'h0;
                        end
                    end
                end
                FR_CMD: begin
                    st_nxt.shreg = cmd_word;
                    st_nxt.bitcnt = st_r.bitcnt + 4'h1;
                    if (fire) begin
                        st_nxt.bitcnt = 4'h0;
                    end
                end
                FR_IDLE: begin
                    st_nxt.fr = FR_IDLE; // bad mode code, wait for chip select
                end
            endcase
        end else if (rd_fall && st_r.fr == FR_DATA && st_r.rcnt <= `LCDD_NIB_LAST) begin
            // a write frame reads one nibble at most before its rewrite
            st_nxt.dout = rd_bit;
            st_nxt.doe = 1'b1;
            st_nxt.rcnt = st_r.rcnt + 3'h1;
            if (st_r.mode == `LCDD_MODE_READ && st_r.rcnt == `LCDD_NIB_LAST) begin
                st_nxt.addr = addr_inc;
                st_nxt.rcnt = 3'h0;
            end
        end

        // crystal accumulator, shared divider and watchdog stage
        st_nxt.acc = (acc_sum >= {1'b0, `LCDD_PCLK_HZ}) ? 24'(acc_sum - {1'b0, `LCDD_PCLK_HZ})
                                                       : acc_sum[23:0];
        if (osc_tick) begin
            st_nxt.div = st_r.div + 15'h0001;
        end
        if (tb_wrap) begin
            st_nxt.wdt_cnt = st_r.wdt_cnt + 3'h1;
            if (st_r.wdt_cnt == `LCDD_WDT_LAST) begin
                st_nxt.wdt_cnt = 3'h0;
                wdt_set = st_r.cfg.watchdog_flag_on;
            end
        end

        // configuration commands
        if (fire) begin
            unique case (cmd)
                C_OSC_BIAS_OFF: begin
                    st_nxt.cfg.osc_on = 1'b0;
                    st_nxt.cfg.bias_on = 1'b0;
                end
                C_OSC_ON: begin
                    // shared code: oscillator start and panel off
                    st_nxt.cfg.osc_on = 1'b1;
                    st_nxt.cfg.bias_on = 1'b0;
                end
                C_BIAS_ON:   st_nxt.cfg.bias_on = 1'b1;
                C_TICK_OFF:  st_nxt.cfg.tick_en = 1'b0;
                C_TICK_ON:   st_nxt.cfg.tick_en = 1'b1;
                C_WDT_OFF:   st_nxt.cfg.watchdog_flag_on = 1'b0;
                C_WDT_ON:    st_nxt.cfg.watchdog_flag_on = 1'b1;
                C_TONE_OFF:  st_nxt.cfg.tone_on = 1'b0;
                C_TICK_CLR:  st_nxt.div = 15'h0000;
                C_WDT_CLR: begin
                    st_nxt.wdt_cnt = 3'h0;
                    st_nxt.wdt_flag = 1'b0;
                end
                C_PANEL: begin
                    st_nxt.cfg.bias_third = cmd_word[1];
                    st_nxt.cfg.commons = cmd_word[4:3];
                end
                C_TONE_HI: begin
                    st_nxt.cfg.tone_on = 1'b1;
                    st_nxt.cfg.tone_low = 1'b0;
                end
                C_TONE_LO: begin
                    st_nxt.cfg.tone_on = 1'b1;
                    st_nxt.cfg.tone_low = 1'b1;
                end
                C_ALARM_OFF: begin
                    st_nxt.cfg.irq_en = 1'b0;
                    st_nxt.wdt_flag = 1'b0;
                end
                C_ALARM_ON:  st_nxt.cfg.irq_en = 1'b1;
                C_RATE:      st_nxt.cfg.rate = cmd_word[3:1];
                C_TEST:      st_nxt.cfg.test_mode = 1'b1;
                C_NORMAL:    st_nxt.cfg.test_mode = 1'b0;
                C_NONE:      st_nxt.cfg = st_r.cfg;
            endcase
        end
        // a timeout in the clearing cycle still lands
        if (wdt_set) begin
            st_nxt.wdt_flag = 1'b1;
        end

        // pins: alarm low on held timeout or on the tick level
        st_nxt.irq_n = ~(st_r.cfg.irq_en & ((st_r.cfg.watchdog_flag_on & st_r.wdt_flag) |
                                            (st_r.cfg.tick_en & tb_level)));
        if (st_r.cfg.tone_on && st_r.cfg.osc_on) begin
            st_nxt.beep[0] = st_r.cfg.tone_low ? st_r.div[`LCDD_TONE_LO_BIT] : st_r.div[`LCDD_TONE_HI_BIT];
            st_nxt.beep[1] = ~st_nxt.beep[0];
        end else begin
            st_nxt.beep = 2'b00;
        end

        // apb slave, answer in the first access cycle
        st_nxt.pready = apb_setup;
        st_nxt.prdata = 32'h0000_0000;
        st_nxt.pslverr = 1'b0;
        if (apb_setup) begin
            if (apb_i.paddr == `LCDD_ADDR_STATUS) begin
                st_nxt.prdata = status_word(st_r);
            end else if (apb_i.paddr == `LCDD_ADDR_CTRL) begin
                st_nxt.prdata[`LCDD_CTRL_LINK] = st_r.link_en;
            end else begin
                st_nxt.pslverr = 1'b1;
            end
        end else if (apb_i.psel && apb_i.penable) begin
            st_nxt.prdata = st_r.prdata;
            st_nxt.pslverr = st_r.pslverr;
        end
        if (apb_write && apb_i.paddr == `LCDD_ADDR_CTRL) begin
            st_nxt.link_en = apb_i.pwdata[`LCDD_CTRL_LINK];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign apb_o  = '{prdata: st_r.prdata, pready: st_r.pready, pslverr: st_r.pslverr};
    assign link_o = '{data: st_r.dout, data_oe: st_r.doe, irq_n: st_r.irq_n, beeper_pair: st_r.beep};

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_cs_abort: assert property (cs_hi |=> (st_r.fr == FR_MODE && st_r.bitcnt == 4'h0 && !link_o.data_oe))
        else $error("frame not aborted by chip select");
    a_read_drive: assert property ((live && rd_fall && !wr_rise && st_r.fr == FR_DATA && st_r.rcnt == 3'h0)
        |=> (link_o.data_oe && link_o.data == $past(rd_bit)))
        else $error("read bit not driven after read strobe fall");
    a_write_store: assert property ((live && wr_rise && st_r.fr == FR_DATA && st_r.mode == `LCDD_MODE_WRITE
        && st_r.wcnt == 3'h3) |=> (st_r.ram_we && st_r.ram_waddr == $past(st_r.addr)
        && st_r.addr == $past(addr_inc)))
        else $error("nibble not stored or address not advanced");
    a_cmd_entry: assert property ((live && wr_rise && st_r.fr == FR_MODE && st_r.bitcnt == 4'h2
        && {st_r.mode[1:0], din} == 3'h4) |=> st_r.fr == FR_CMD ##1 st_r.bitcnt == 4'h0)
        else $error("command mode code not taken");
    a_osc_off: assert property ((fire && cmd == C_OSC_BIAS_OFF) |=> (!st_r.cfg.osc_on && !st_r.cfg.bias_on))
        else $error("oscillator or bias still on");
    a_osc_on: assert property ((fire && cmd == C_OSC_ON) |=> st_r.cfg.osc_on)
        else $error("oscillator not started");
    a_rate_set: assert property (fire && cmd == C_RATE |=> st_r.cfg.rate == $past(cmd_word[3:1]))
        else $error("rate selection not taken");
    a_alarm_hold: assert property ((st_r.wdt_flag && st_r.cfg.irq_en && st_r.cfg.watchdog_flag_on)
        |=> !link_o.irq_n)
        else $error("alarm not held low after timeout");
    a_beeper_off: assert property (!st_r.cfg.tone_on |=> link_o.beeper_pair == 2'b00)
        else $error("beeper pair driven while off");
    a_unknown_cmd: assert property ((fire && cmd == C_NONE) |=> $stable(st_r.cfg))
        else $error("unknown command changed configuration");
    a_panel_cfg: assert property ((fire && cmd == C_PANEL) |=> (st_r.cfg.commons != 2'b11
        && st_r.cfg.bias_third == $past(cmd_word[1])))
        else $error("panel configuration wrong");
    a_apb_ready: assert property (apb_setup |=> (apb_o.pready ##1 !apb_o.pready))
        else $error("apb answer not one access cycle");

    c_read_nibble: cover property (live && rd_fall && st_r.mode == `LCDD_MODE_READ && st_r.rcnt == 3'h3);
    c_write_nibble: cover property (st_r.ram_we);
    c_cmd_run: cover property (fire ##[1:300] fire);
    c_wdt_timeout: cover property (!st_r.wdt_flag ##1 st_r.wdt_flag);
endmodule : lcdd_decoder

// file: verification/lcdd_host.sv
// host model: chip select, strobes and serial data toward the decoder
// assumes pclk at 10 MHz; one strobe period is 8 pclk, 800 ns
module lcdd_host (
    input  wire logic                     pclk,
    input  wire lcdd_pkg::lcdd_link_out_t dev,
    output lcdd_pkg::lcdd_link_in_t       lnk
);
    timeunit 1ns;
    timeprecision 1ns;
    logic cs_n = 1'b1, wr_n = 1'b1, rd_n = 1'b1, hd = 1'b0, own = 1'b0;
    // a released line shows the inverse of the last bit, so a stale level never passes for read data
    assign lnk = '{data: own ? hd : (dev.data_oe ? dev.data : ~dev.data), rd_n: rd_n, wr_n: wr_n, cs_n: cs_n};
    task automatic half();
        repeat (4) @(posedge pclk);
    endtask : half
    task automatic cs(input logic v);
        own <= 1'b0;
        cs_n <= v;
        half();
    endtask : cs
    // msb first; data moves with the strobe fall, so it is steady at the rise
    task automatic wv(input logic [8:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            own <= 1'b1;
            hd <= v[i];
            wr_n <= 1'b0;
            half();
            wr_n <= 1'b1;
            half();
        end
    endtask : wv
    // one command run: the mode code once, then bare words
    task automatic cmd(input logic [8:0] w[$]);
        cs(1'b0);
        wv(9'h004, 3);
        foreach (w[i]) wv(w[i], 9);
        cs(1'b1);
    endtask : cmd
    // bits are taken after the strobe rise, before the next fall
    task automatic r4(output logic [3:0] v);
        own <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            rd_n <= 1'b0;
            half();
            rd_n <= 1'b1;
            half();
            v[i] = lnk.data;
        end
    endtask : r4
endmodule : lcdd_host

// file: verification/lcdd_decoder_test.sv
// self-checking bench for the serial display command decoder
// assumes one-cycle apb answers and the host model on the serial link
`include "lcdd_params.svh"
module lcdd_decoder_test;
    timeunit 1ns;
    timeprecision 1ns;
    import lcdd_pkg::*;
    logic           pclk = 1'b0;
    logic           presetn = 1'b0;
    lcdd_apb_req_t  req = '0;
    lcdd_apb_rsp_t  rsp;
    lcdd_link_in_t  lnk;
    lcdd_link_out_t lko;
    logic [3:0]     nb;
    int             fails = 0, n_checks = 0, cyc = 0;
    lcdd_decoder dut_u (.pclk(pclk), .presetn(presetn), .apb_i(req), .apb_o(rsp), .link_i(lnk), .link_o(lko));
    lcdd_host host_u (.pclk(pclk), .dev(lko), .lnk(lnk));
    initial forever #50 pclk = ~pclk;
    // the tests need under 5000 cycles; a hang counts as a mismatch
    always @(posedge pclk) if (++cyc == 20000) begin
        fails++;
        complete_run();
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // the request stands until pready is sampled high at a rising edge; every transfer checks pslverr
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do @(posedge pclk); while (rsp.pready !== 1'b1);
        chk("pslverr", {31'h0, a > `LCDD_ADDR_CTRL}, {31'h0, rsp.pslverr});
        if (!w) chk("prdata", e, rsp.prdata);
        req <= '0;
    endtask : apb
    task complete_run();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `LCDD_ADDR_STATUS, 32'h0, 32'h1c00);
        // status is read-only, a write must leave it as it was
        apb(1'b1, `LCDD_ADDR_STATUS, 32'h0000_e3ff, 32'h0);
        apb(1'b0, `LCDD_ADDR_STATUS, 32'h0, 32'h1c00);
        apb(1'b0, `LCDD_ADDR_CTRL, 32'h0, 32'h1);
        apb(1'b0, 8'h08, 32'h0, 32'h0);
        $display("test registers done");
        // oscillator, bias, 4 commons at third bias, low tone, rate 3, alarm on, watchdog on; don't-care bits set
        host_u.cmd('{9'h003, 9'h007, 9'h056, 9'h0df, 9'h167, 9'h110, 9'h00f});
        apb(1'b0, `LCDD_ADDR_STATUS, 32'h0, 32'h0efb);
        chk("beeper pair", 32'h1, {31'h0, lko.beeper_pair[1] ^ lko.beeper_pair[0]});
        chk("alarm pin", 32'h1, {31'h0, lko.irq_n});
        // with the link held off a stop command must be ignored
        apb(1'b1, `LCDD_ADDR_CTRL, 32'h0, 32'h0);
        apb(1'b0, `LCDD_ADDR_CTRL, 32'h0, 32'h0);
        host_u.cmd('{9'h001});
        apb(1'b0, `LCDD_ADDR_STATUS, 32'h0, 32'h0efb);
        apb(1'b1, `LCDD_ADDR_CTRL, 32'h1, 32'h0);
        // a word cut off by chip select, then ab=11, tone off, all off, alarm off, normal mode
        host_u.cs(1'b0);
        host_u.wv(9'h024, 6);
        host_u.cs(1'b1);
        host_u.cmd('{9'h058, 9'h010, 9'h001, 9'h100, 9'h1c6});
        apb(1'b0, `LCDD_ADDR_STATUS, 32'h0, 32'h0ea8);
        chk("beeper pair", 32'h0, {30'h0, lko.beeper_pair});
        $display("test commands done");
        // nibbles go lsb first, so these literals are bit-reversed: a, 3, then c
        host_u.cs(1'b0);
        host_u.wv(9'h145, 9);
        host_u.wv(9'h005, 4);
        host_u.wv(9'h00c, 4);
        host_u.cs(1'b1);
        host_u.cs(1'b0);
        host_u.wv(9'h145, 9);
        host_u.r4(nb);
        chk("rmw nibble", 32'ha, {28'h0, nb});
        host_u.wv(9'h003, 4);
        host_u.r4(nb);
        chk("next nibble", 32'h3, {28'h0, nb});
        host_u.cs(1'b1);
        host_u.cs(1'b0);
        host_u.wv(9'h185, 9);
        host_u.r4(nb);
        chk("read nibble", 32'hc, {28'h0, nb});
        host_u.cs(1'b1);
        $display("test memory done");
        complete_run();
    end
endmodule : lcdd_decoder_test
